/* core/pixel_lut_shading_mirror.sv */
// Purpose: shading correction, look-up table and line mirror on pixels
// Assumes: one pixel per valid cycle, lines no wider than MAX_W
// Notes: output lags input by one line; memories hold no reset
`timescale 1ns/100ps
module pixel_lut_shading_mirror (
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // pixel input
  input wire logic [11:0] pix_in,
  input wire logic pix_valid,
  input wire logic pix_sof,
  input wire logic pix_eol,
  // pixel output
  output logic [7:0] out_pix,
  output logic out_valid,
  output logic out_sof,
  output logic out_eol
);
  logic [7:0] lut [pc_pkg::LUT_DEPTH];
  logic [7:0] gamma_rom [pc_pkg::LUT_DEPTH];
  logic [7:0] exbuf [pc_pkg::EXBUF_BYTES];
  logic [7:0] shd [pc_pkg::NPIX];
  logic [13:0] acc [pc_pkg::NPIX];
  logic [7:0] lb [2 * pc_pkg::MAX_W];
  logic gamma_on, lut_user, mirror_en, shade_en;
  logic [7:0] avg_count;
  logic [6:0] gen_w;
  logic [5:0] gen_h;
  logic [9:0] brightest;
  pc_pkg::copy_e cp_state;
  logic [11:0] cp_cnt;
  logic cp_blk;
  pc_pkg::gen_e gen_state;
  logic [4:0] g_frames;
  logic g_first;
  logic [11:0] g_idx;
  logic [13:0] g_max;
  logic [6:0] g_w;
  logic [5:0] g_h;
  logic [5:0] col, row, cur_x, cur_y;
  logic [11:0] idx, shd_idx;
  logic [9:0] p10, corr, s1_corr;
  logic [7:0] fac, lut_q, next_fac;
  logic [18:0] prod;
  logic [21:0] quot;
  logic [4:0] n_avg;
  logic in_win, in_rng, g_in_win, gen_busy, lut_use;
  logic gamma_wr, gen_go, xc_go, cp_end;
  logic s1_valid, s1_sof, s1_eol, line_sof, mirror_act;
  logic [5:0] s1_x;
  logic wb, rd_act, rd_bank, rd_mir, rd_sof;
  logic [5:0] rd_len, rd_cnt, rd_ix;

  for (genvar g = 0; g < pc_pkg::LUT_DEPTH; g++) begin : g_rom
    assign gamma_rom[g] = pc_pkg::gamma_val(g);
  end

  // bus decode; busy engines refuse new commands
  always_comb begin
    gen_busy = gen_state != pc_pkg::G_IDLE;
    gamma_wr = wr && addr == pc_pkg::GAMMA_OFS && cp_state == pc_pkg::CP_IDLE;
    gen_go = wr && addr == pc_pkg::GEN_OFS && wdata[pc_pkg::GEN_BIT]
      && gen_state == pc_pkg::G_IDLE && cp_state == pc_pkg::CP_IDLE;
    xc_go = wr && addr == pc_pkg::XCMD_OFS && wdata[1:0] != 2'h0
      && cp_state == pc_pkg::CP_IDLE && !gen_busy;
    lut_use = gamma_on || lut_user;
    // counts above 16 would overflow the accumulators
    if (avg_count == 8'h00)
      n_avg = 5'h01;
    else if (avg_count > 8'(pc_pkg::AVG_MAX))
      n_avg = pc_pkg::AVG_MAX;
    else
      n_avg = avg_count[4:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mirror_en <= 1'b0;
      shade_en <= 1'b0;
      avg_count <= pc_pkg::AVG_RESET;
    end else if (wr && addr == pc_pkg::CTRL_OFS) begin
      mirror_en <= wdata[pc_pkg::MIRROR_BIT];
      shade_en <= wdata[pc_pkg::SHADE_BIT];
    end else if (wr && addr == pc_pkg::AVG_OFS) begin
      avg_count <= wdata[7:0];
    end
  end

  // one table source at a time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gamma_on <= 1'b0;
      lut_user <= 1'b0;
    end else if (gamma_wr) begin
      gamma_on <= wdata[pc_pkg::GAMMA_BIT];
      if (wdata[pc_pkg::GAMMA_BIT])
        lut_user <= 1'b0;
    end else if (cp_state == pc_pkg::CP_LUT && cp_end) begin
      lut_user <= 1'b1;
      gamma_on <= 1'b0;
    end
  end

  // copy engine between exchange buffer, table and reference image
  always_comb begin
    shd_idx = {cp_blk, cp_cnt[10:0]};
    case (cp_state)
      pc_pkg::CP_LUT, pc_pkg::CP_GAMMA: cp_end = cp_cnt[9:0] == pc_pkg::LUT_LAST;
      pc_pkg::CP_SHD_IN, pc_pkg::CP_SHD_OUT:
        cp_end = cp_cnt[10:0] == pc_pkg::BLK_LAST || shd_idx == pc_pkg::PIX_LAST;
      default: cp_end = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_state <= pc_pkg::CP_IDLE;
      cp_cnt <= 12'h000;
      cp_blk <= 1'b0;
    end else begin
      case (cp_state)
        pc_pkg::CP_IDLE: begin
          cp_cnt <= 12'h000;
          if (gamma_wr && wdata[pc_pkg::GAMMA_BIT] && !gamma_on) begin
            cp_state <= pc_pkg::CP_GAMMA;
          end else if (xc_go) begin
            cp_blk <= wdata[pc_pkg::XBLK_BIT];
            case (wdata[1:0])
              pc_pkg::XC_LUT: cp_state <= pc_pkg::CP_LUT;
              pc_pkg::XC_SHD_IN: cp_state <= pc_pkg::CP_SHD_IN;
              default: cp_state <= pc_pkg::CP_SHD_OUT;
            endcase
          end
        end
        default: begin
          cp_cnt <= cp_cnt + 12'h001;
          if (cp_end)
            cp_state <= pc_pkg::CP_IDLE;
        end
      endcase
    end
  end

  // volatile table, no reset and no retention
  always_ff @(posedge clk) begin
    if (cp_state == pc_pkg::CP_LUT)
      lut[cp_cnt[9:0]] <= exbuf[cp_cnt[9:0]];
    else if (cp_state == pc_pkg::CP_GAMMA)
      lut[cp_cnt[9:0]] <= gamma_rom[cp_cnt[9:0]];
  end

  // host writes land while no upload runs
  always_ff @(posedge clk) begin
    if (cp_state == pc_pkg::CP_SHD_OUT) begin
      exbuf[cp_cnt[10:0]] <= shd[shd_idx];
    end else if (wr && addr[31:11] == pc_pkg::EXBUF_BASE[31:11]) begin
      for (int b = 0; b < 4; b++)
        exbuf[{addr[10:2], 2'(b)}] <= wdata[8 * b +: 8];
    end
  end

  // pixel position and shading stage
  always_comb begin
    p10 = pix_in[11:2];
    cur_x = pix_sof ? 6'h00 : col;
    cur_y = pix_sof ? 6'h00 : row;
    idx = {cur_y, cur_x};
    in_rng = cur_y < 6'(pc_pkg::MAX_H);
    in_win = {1'b0, cur_x} < gen_w && cur_y < gen_h;
    fac = (shade_en && in_win) ? shd[idx] : 8'h00;
    prod = {9'h000, p10} * {10'h000, {1'b0, fac} + pc_pkg::FAC_ONE};
    corr = prod[18] ? 10'h3FF : prod[17:8];
    lut_q = lut_use ? lut[s1_corr] : s1_corr[9:2];
    rd_ix = rd_mir ? rd_len - rd_cnt : rd_cnt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col <= 6'h00;
      row <= 6'h00;
    end else if (pix_valid) begin
      col <= pix_eol ? 6'h00 : cur_x + 6'h01;
      row <= pix_eol ? cur_y + 6'h01 : cur_y;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_valid <= 1'b0;
      s1_sof <= 1'b0;
      s1_eol <= 1'b0;
      s1_x <= 6'h00;
      s1_corr <= 10'h000;
    end else begin
      s1_valid <= pix_valid;
      s1_sof <= pix_valid && pix_sof;
      s1_eol <= pix_valid && pix_eol;
      s1_x <= cur_x;
      s1_corr <= corr;
    end
  end

  // reference generation: average, find peak, derive factors
  always_comb begin
    g_in_win = {1'b0, g_idx[5:0]} < g_w && g_idx[11:6] < g_h;
    quot = {g_max, 8'h00} / {8'h00, acc[g_idx]};
    if (acc[g_idx] == 14'h0000 || quot >= 22'h000200)
      next_fac = 8'hFF;
    else if (quot < 22'h000100)
      next_fac = 8'h00;
    else
      next_fac = quot[7:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_state <= pc_pkg::G_IDLE;
      g_frames <= 5'h00;
      g_first <= 1'b0;
      g_idx <= 12'h000;
      g_max <= 14'h0000;
      g_w <= 7'h00;
      g_h <= 6'h00;
      gen_w <= 7'h00;
      gen_h <= 6'h00;
      brightest <= 10'h000;
    end else begin
      case (gen_state)
        pc_pkg::G_IDLE: begin
          if (gen_go)
            gen_state <= pc_pkg::G_WAIT;
          else if (cp_state == pc_pkg::CP_SHD_IN && cp_end) begin
            gen_w <= 7'(pc_pkg::MAX_W);
            gen_h <= 6'(pc_pkg::MAX_H);
          end
        end
        pc_pkg::G_WAIT: begin
          g_frames <= 5'h00;
          g_first <= 1'b1;
          g_w <= 7'h00;
          g_h <= 6'h00;
          if (pix_valid && pix_sof)
            gen_state <= pc_pkg::G_ACC;
        end
        pc_pkg::G_ACC: begin
          if (pix_valid && pix_sof) begin
            g_first <= 1'b0;
            if (g_frames + 5'h01 == n_avg) begin
              gen_state <= pc_pkg::G_MAX;
              g_idx <= 12'h000;
              g_max <= 14'h0000;
            end else begin
              g_frames <= g_frames + 5'h01;
            end
          end else if (pix_valid && g_first && in_rng) begin
            // window is the first frame captured
            if ({1'b0, cur_x} >= g_w)
              g_w <= {1'b0, cur_x} + 7'h01;
            if (cur_y >= g_h)
              g_h <= cur_y + 6'h01;
          end
        end
        pc_pkg::G_MAX: begin
          if (g_in_win && acc[g_idx] > g_max)
            g_max <= acc[g_idx];
          g_idx <= g_idx + 12'h001;
          if (g_idx == pc_pkg::PIX_LAST) begin
            gen_state <= pc_pkg::G_FAC;
            g_idx <= 12'h000;
          end
        end
        pc_pkg::G_FAC: begin
          g_idx <= g_idx + 12'h001;
          if (g_idx == pc_pkg::PIX_LAST) begin
            gen_state <= pc_pkg::G_IDLE;
            gen_w <= g_w;
            gen_h <= g_h;
            brightest <= 10'(g_max / {9'h000, n_avg});
          end
        end
        default: gen_state <= pc_pkg::G_IDLE;
      endcase
    end
  end

  // sum of frames; the factor quotient of peak over sum cancels the common divisor
  always_ff @(posedge clk) begin
    if (gen_state == pc_pkg::G_ACC && pix_valid && in_rng
        && !(pix_sof && g_frames + 5'h01 == n_avg))
      acc[idx] <= (g_first && !pix_sof ? 14'h0000 : acc[idx])
        + {4'h0, p10};
    else if (gen_state == pc_pkg::G_WAIT && pix_valid && pix_sof)
      acc[idx] <= {4'h0, p10};
  end

  always_ff @(posedge clk) begin
    if (gen_state == pc_pkg::G_FAC)
      shd[g_idx] <= g_in_win ? next_fac : 8'h00;
    else if (cp_state == pc_pkg::CP_SHD_IN)
      shd[shd_idx] <= exbuf[cp_cnt[10:0]];
  end

  // line buffer and mirror; mirror mode is sampled per frame
  always_ff @(posedge clk) begin
    if (s1_valid)
      lb[{wb, s1_x}] <= lut_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mirror_act <= 1'b0;
      line_sof <= 1'b0;
      wb <= 1'b0;
    end else begin
      if (s1_sof)
        mirror_act <= mirror_en;
      if (s1_eol) begin
        wb <= ~wb;
        line_sof <= 1'b0;
      end else if (s1_sof) begin
        line_sof <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_act <= 1'b0;
      rd_bank <= 1'b0;
      rd_mir <= 1'b0;
      rd_sof <= 1'b0;
      rd_len <= 6'h00;
      rd_cnt <= 6'h00;
    end else if (s1_eol) begin
      rd_act <= !gen_busy;
      rd_bank <= wb;
      rd_mir <= s1_sof ? mirror_en : mirror_act;
      rd_sof <= line_sof || s1_sof;
      rd_len <= s1_x;
      rd_cnt <= 6'h00;
    end else if (rd_act) begin
      rd_cnt <= rd_cnt + 6'h01;
      if (rd_cnt == rd_len)
        rd_act <= 1'b0;
    end
  end

  // reversal reads the line from its last pixel back to its first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_pix <= 8'h00;
      out_valid <= 1'b0;
      out_sof <= 1'b0;
      out_eol <= 1'b0;
    end else begin
      out_pix <= rd_act ? lb[{rd_bank, rd_ix}] : 8'h00;
      out_valid <= rd_act;
      out_sof <= rd_act && rd_sof && rd_cnt == 6'h00;
      out_eol <= rd_act && rd_cnt == rd_len;
    end
  end

  // read data stand one cycle, zero otherwise and when unmapped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (!rd) begin
      rdata <= 32'h00000000;
    end else if (addr[31:11] == pc_pkg::EXBUF_BASE[31:11]) begin
      rdata <= {exbuf[{addr[10:2], 2'h3}], exbuf[{addr[10:2], 2'h2}],
                exbuf[{addr[10:2], 2'h1}], exbuf[{addr[10:2], 2'h0}]};
    end else begin
      case (addr)
        pc_pkg::GAMMA_OFS: rdata <= 32'(gamma_on) << pc_pkg::GAMMA_BIT;
        pc_pkg::CTRL_OFS: rdata <= {30'h0, shade_en, mirror_en};
        pc_pkg::AVG_OFS: rdata <= {24'h000000, avg_count};
        pc_pkg::STATUS_OFS:
          rdata <= {6'h00, brightest, 12'h000, lut_user,
                    cp_state != pc_pkg::CP_IDLE, gen_busy, gamma_on};
        default: rdata <= 32'h00000000;
      endcase
    end
  end

  chk_gamma_bit: assert property (@(posedge clk) disable iff (!rst_n)
    gamma_wr |=> gamma_on == $past(wdata[pc_pkg::GAMMA_BIT]))
    else $error("gamma bit not taken");
  chk_lut_excl: assert property (@(posedge clk) disable iff (!rst_n)
    !(gamma_on && lut_user))
    else $error("gamma and user table both active");
  chk_gamma_fill: assert property (@(posedge clk) disable iff (!rst_n)
    cp_state == pc_pkg::CP_GAMMA |=>
      lut[$past(cp_cnt[9:0])] == gamma_rom[$past(cp_cnt[9:0])])
    else $error("gamma curve entry wrong");
  chk_shade_gain: assert property (@(posedge clk) disable iff (!rst_n)
    pix_valid |=> s1_corr >= $past(p10)
      && {1'b0, s1_corr} <= {$past(p10), 1'b0})
    else $error("shading gain outside one to two");
  chk_shade_window: assert property (@(posedge clk) disable iff (!rst_n)
    (pix_valid && !in_win) |=> s1_corr == $past(p10))
    else $error("pixel outside window corrected");
  chk_avg_frames: assert property (@(posedge clk) disable iff (!rst_n)
    (gen_state == pc_pkg::G_ACC ##1 gen_state == pc_pkg::G_MAX)
      |-> $past(g_frames) + 5'h01 == n_avg)
    else $error("wrong number of frames averaged");
  chk_peak_unity: assert property (@(posedge clk) disable iff (!rst_n)
    (gen_state == pc_pkg::G_FAC && g_in_win && acc[g_idx] == g_max
      && g_max != 14'h0000) |=> shd[$past(g_idx)] == 8'h00)
    else $error("brightest pixel factor not unity");
  chk_gen_suspend: assert property (@(posedge clk) disable iff (!rst_n)
    (gen_busy && !rd_act) |=> !out_valid)
    else $error("output during generation");
  chk_mirror_frame: assert property (@(posedge clk) disable iff (!rst_n)
    !s1_sof |=> $stable(mirror_act))
    else $error("mirror changed inside frame");
  chk_mirror_order: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_act && rd_mir) |-> rd_ix + rd_cnt == rd_len)
    else $error("mirrored index wrong");
endmodule

/* core/pc_pkg.sv */
// Purpose: shared constants and types of the pixel correction stage
// Assumes: byte addresses on the register port, 32-bit data
// Notes: frame geometry is bounded by MAX_W x MAX_H
package pc_pkg;
  localparam int LUT_DEPTH = 1024;
  localparam int MAX_W = 64;
  localparam int MAX_H = 48;
  localparam int NPIX = 3072;
  localparam int EXBUF_BYTES = 2048;
  localparam real GAMMA_EXP = 0.45;
  localparam real GAMMA_IN_MAX = 1023.0;
  localparam real GAMMA_OUT_MAX = 255.0;
  // register byte addresses
  localparam logic [31:0] GAMMA_OFS = 32'hF0F00818;
  localparam logic [31:0] CTRL_OFS = 32'hF0F10000;
  localparam logic [31:0] GEN_OFS = 32'hF0F10004;
  localparam logic [31:0] AVG_OFS = 32'hF0F10008;
  localparam logic [31:0] STATUS_OFS = 32'hF0F1000C;
  localparam logic [31:0] XCMD_OFS = 32'hF0F10010;
  localparam logic [31:0] EXBUF_BASE = 32'hF0F20000;
  // field positions
  localparam int GAMMA_BIT = 6;
  localparam int MIRROR_BIT = 0;
  localparam int SHADE_BIT = 1;
  localparam int GEN_BIT = 0;
  localparam int XBLK_BIT = 8;
  localparam int BRIGHT_LSB = 16;
  // reset values and arithmetic constants
  localparam logic [7:0] AVG_RESET = 8'h04;
  localparam logic [4:0] AVG_MAX = 5'h10;
  localparam logic [8:0] FAC_ONE = 9'h100;
  localparam logic [9:0] LUT_LAST = 10'h3FF;
  localparam logic [10:0] BLK_LAST = 11'h7FF;
  localparam logic [11:0] PIX_LAST = 12'hBFF;
  // exchange buffer commands
  localparam logic [1:0] XC_LUT = 2'h1;
  localparam logic [1:0] XC_SHD_IN = 2'h2;
  localparam logic [1:0] XC_SHD_OUT = 2'h3;

  typedef enum {CP_IDLE, CP_LUT, CP_GAMMA, CP_SHD_IN, CP_SHD_OUT} copy_e;
  typedef enum {G_IDLE, G_WAIT, G_ACC, G_MAX, G_FAC} gen_e;

  function automatic logic [7:0] gamma_val(input int i);
    real r;
    r = $pow(i / GAMMA_IN_MAX, GAMMA_EXP) * GAMMA_OUT_MAX;
    return 8'($rtoi(r + 0.5));
  endfunction
endpackage

/* tb/host_model.sv */
// Purpose: host side of the register port of the pixel stage
// Assumes: one clock, strobes one cycle long, slave never stalls
// Notes: status is polled, there is no interrupt to wait on
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [31:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  initial begin
    addr = 32'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic write_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic read_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    // sample mid-cycle, where the data are settled
    @(negedge clk);
    d = rdata;
  endtask

  // bounded poll; a hang is left to the bench watchdog
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h6;
    for (int i = 0; i < 4000 && (s & 32'h6) != 32'h0; i++) begin
      read_reg(pc_pkg::STATUS_OFS, s);
    end
  endtask

  // whole block through the exchange buffer, then the copy command
  task automatic load_block(input logic [7:0] b[$], input logic [1:0] cmd,
                            input logic blk);
    for (int k = 0; k < b.size() / 4; k++) begin
      write_reg(pc_pkg::EXBUF_BASE + 32'(4 * k),
                {b[4*k+3], b[4*k+2], b[4*k+1], b[4*k]});
    end
    write_reg(pc_pkg::XCMD_OFS, {23'h0, blk, 6'h0, cmd});
    wait_idle();
  endtask
endmodule

/* tb/tb_pixel_lut_shading_mirror.sv */
// Purpose: self-checking bench of the pixel correction stage
// Assumes: row 0 only is shaded, every checked line but one starts a frame
// Notes: one generation run on 8-pixel frames, checked via store
`timescale 1ns/100ps
module tb_pixel_lut_shading_mirror;
  logic clk;
  logic rst_n;
  logic [31:0] addr, wdata, rdata, r;
  logic wr, rd;
  logic [11:0] pix_in;
  logic pix_valid, pix_sof, pix_eol;
  logic [7:0] out_pix;
  logic out_valid, out_sof, out_eol, first_sof, last_eol;
  int num_errors, cmp_count, cycles, seed;
  int lut[1024];
  int fac[64];
  bit tbl_on, shd_on, mir, mir_req;
  logic [7:0] got[$];
  logic [7:0] q[$];
  int pv[$];
  int sum[8];
  int peak, w;

  pixel_lut_shading_mirror i_pixel_lut_shading_mirror (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pix_in(pix_in), .pix_valid(pix_valid),
    .pix_sof(pix_sof), .pix_eol(pix_eol), .out_pix(out_pix),
    .out_valid(out_valid), .out_sof(out_sof), .out_eol(out_eol)
  );
  host_model i_host_model (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (out_valid) begin
      if (got.size() == 0) first_sof = out_sof;
      last_eol = out_eol;
      got.push_back(out_pix);
    end
  end

  // watchdog, far above the roughly 14000 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  function automatic int model(int p, int x);
    int c;
    c = p >> 2;
    if (shd_on) c = (c * (256 + fac[x])) >> 8;
    if (c > 1023) c = 1023;
    if (tbl_on) return lut[c];
    return c >> 2;
  endfunction

  task automatic send_line(input int n, input bit sof, input int base,
                           input int mask);
    pv.delete();
    for (int i = 0; i < n; i++) pv.push_back(base + ($random(seed) & mask));
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      pix_valid <= 1'b1;
      pix_in <= 12'(pv[i]);
      pix_sof <= sof && i == 0;
      pix_eol <= i == n - 1;
    end
    @(posedge clk);
    pix_valid <= 1'b0;
    pix_sof <= 1'b0;
    pix_eol <= 1'b0;
  endtask

  task automatic run_line(input int n, input bit sof);
    int e[$];
    int j;
    send_line(n, sof, 0, 32'hFFF);
    // mirror state only moves at a frame start
    if (sof) mir = mir_req;
    for (int i = 0; i < n; i++) begin
      j = mir ? n - 1 - i : i;
      e.push_back(model(pv[j], j));
    end
    repeat (n + 4) @(posedge clk);
    cmp(32'(got.size()), 32'(n));
    for (int i = 0; i < n && i < got.size(); i++) begin
      cmp({24'h0, got[i]}, 32'(e[i]));
    end
    cmp({31'h0, first_sof}, {31'h0, sof});
    cmp({31'h0, last_eol}, 32'h1);
    got.delete();
  endtask

  initial begin
    rst_n = 1'b0;
    pix_in = 12'h0;
    pix_valid = 1'b0;
    pix_sof = 1'b0;
    pix_eol = 1'b0;
    seed = 87;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    i_host_model.read_reg(pc_pkg::AVG_OFS, r);
    cmp(r, 32'h4);
    i_host_model.read_reg(pc_pkg::STATUS_OFS, r);
    cmp(r, 32'h0);
    i_host_model.read_reg(32'hF0F10040, r);
    cmp(r, 32'h0);
    i_host_model.write_reg(pc_pkg::AVG_OFS, 32'h8);
    i_host_model.read_reg(pc_pkg::AVG_OFS, r);
    cmp(r, 32'h8);
    run_line(16, 1'b1);
    mir_req = 1'b1;
    i_host_model.write_reg(pc_pkg::CTRL_OFS, 32'h1);
    run_line(16, 1'b0);
    run_line(16, 1'b1);
    mir_req = 1'b0;
    i_host_model.write_reg(pc_pkg::CTRL_OFS, 32'h0);
    run_line(12, 1'b1);
    // factors of row 0 only, the rest of the block stays unknown
    for (int i = 0; i < 64; i++) begin
      fac[i] = $random(seed) & 32'hFF;
      q.push_back(8'(fac[i]));
    end
    i_host_model.load_block(q, pc_pkg::XC_SHD_IN, 1'b0);
    shd_on = 1'b1;
    i_host_model.write_reg(pc_pkg::CTRL_OFS, 32'h2);
    run_line(40, 1'b1);
    q.delete();
    for (int i = 0; i < 1024; i++) begin
      lut[i] = $random(seed) & 32'hFF;
      q.push_back(8'(lut[i]));
    end
    i_host_model.load_block(q, pc_pkg::XC_LUT, 1'b0);
    tbl_on = 1'b1;
    i_host_model.read_reg(pc_pkg::STATUS_OFS, r);
    cmp(r & 32'hF, 32'h8);
    run_line(30, 1'b1);
    for (int i = 0; i < 1024; i++) begin
      lut[i] = $rtoi($pow(i / 1023.0, 0.45) * 255.0 + 0.5);
    end
    i_host_model.write_reg(pc_pkg::GAMMA_OFS, 32'h40);
    i_host_model.wait_idle();
    i_host_model.read_reg(pc_pkg::STATUS_OFS, r);
    cmp(r & 32'hF, 32'h1);
    i_host_model.read_reg(pc_pkg::GAMMA_OFS, r);
    cmp(r & 32'h40, 32'h40);
    run_line(50, 1'b1);
    i_host_model.write_reg(pc_pkg::GAMMA_OFS, 32'h0);
    i_host_model.wait_idle();
    tbl_on = 1'b0;
    run_line(20, 1'b1);
    // reference from 16 one-line frames of 8 pixels
    i_host_model.write_reg(pc_pkg::AVG_OFS, 32'h10);
    // image size differs from the loaded block, so regenerate
    i_host_model.write_reg(pc_pkg::GEN_OFS, 32'h1);
    for (int i = 0; i < 8; i++) sum[i] = 0;
    for (int f = 0; f < 17; f++) begin
      // background only, peak far below full scale
      send_line(8, 1'b1, 32'h400, 32'h3FF);
      for (int i = 0; i < 8 && f < 16; i++) sum[i] += pv[i] >> 2;
      repeat (9) @(posedge clk);
    end
    i_host_model.wait_idle();
    cmp(32'(got.size()), 32'h0);
    got.delete();
    peak = 0;
    for (int i = 0; i < 8; i++) begin
      if (sum[i] > peak) peak = sum[i];
    end
    for (int i = 0; i < 64; i++) begin
      fac[i] = 0;
      if (i < 8) fac[i] = (peak * 256) / sum[i] - 256;
      if (fac[i] > 255) fac[i] = 255;
      if (fac[i] < 0) fac[i] = 0;
    end
    i_host_model.read_reg(pc_pkg::STATUS_OFS, r);
    cmp((r >> 16) & 32'h3FF, 32'(peak / 16));
    i_host_model.write_reg(pc_pkg::XCMD_OFS, 32'h3);
    i_host_model.wait_idle();
    for (int k = 0; k < 3; k++) begin
      i_host_model.read_reg(pc_pkg::EXBUF_BASE + 32'(4 * k), r);
      w = fac[4*k] | (fac[4*k+1] << 8) | (fac[4*k+2] << 16)
        | (fac[4*k+3] << 24);
      cmp(r, 32'(w));
    end
    run_line(12, 1'b1);
    end_of_test();
  end
endmodule
